// >>> hdl/fsc_pkg.sv
// Package for the flash status and configuration register block.
// Assumes a 50 MHz system clock and a serial link clocked by the host.
package fsc_pkg;

   // Command opcodes
   localparam logic [7:0] OP_READ_STATUS     = 8'h05;
   localparam logic [7:0] OP_READ_CONFIG     = 8'h15;
   localparam logic [7:0] OP_LATCH_SET       = 8'h06;
   localparam logic [7:0] OP_LATCH_CLEAR     = 8'h04;
   localparam logic [7:0] OP_STATUS_WRITE    = 8'h01;
   localparam logic [7:0] OP_PAGE_WRITE      = 8'h02;
   localparam logic [7:0] OP_SECTOR_WIPE     = 8'h20;
   localparam logic [7:0] OP_HALF_BLOCK_WIPE = 8'h52;
   localparam logic [7:0] OP_BLOCK_WIPE      = 8'hD8;
   localparam logic [7:0] OP_ARRAY_WIPE      = 8'h60;
   localparam logic [7:0] OP_ARRAY_WIPE_ALT  = 8'hC7;

   // Frame lengths in serial clock edges
   localparam logic [5:0] BITS_OPCODE  = 6'h08;
   localparam logic [5:0] BITS_ONE     = 6'h10;
   localparam logic [5:0] BITS_TWO     = 6'h18;
   localparam logic [5:0] BITS_THREE   = 6'h20;
   localparam logic [5:0] BITS_PAGE    = 6'h28;
   localparam logic [5:0] BITS_MAX     = 6'h3F;

   // Configuration byte field positions
   localparam int CF1_LOW_END = 3;
   localparam int CF1_WAIT    = 6;
   localparam int CF2_PERF    = 1;

   // Reset values
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] CFG_RST    = 8'h00;

   // Protection geometry: 128 blocks, block index in address bits 22..16
   localparam logic [7:0] BLOCK_COUNT = 8'h80;
   localparam int         BLK_LSB     = 16;

   // Wait cycles of the dual and quad reads
   localparam logic [3:0] DUAL_WAIT_SHORT = 4'h4;
   localparam logic [3:0] DUAL_WAIT_LONG  = 4'h8;
   localparam logic [3:0] QUAD_WAIT_SHORT = 4'h6;
   localparam logic [3:0] QUAD_WAIT_LONG  = 4'hA;

   // Self-timed cycle lengths, least times rounded up
   localparam int CLK_PERIOD_NS        = 20;
   localparam int PAGE_WRITE_TIME_NS   = 3000;
   localparam int WIPE_TIME_NS         = 9000;
   localparam int STATUS_WRITE_TIME_NS = 5000;
   localparam logic [15:0] PAGE_WRITE_CYCLES =
      16'((PAGE_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] WIPE_CYCLES =
      16'((WIPE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] STATUS_WRITE_CYCLES =
      16'((STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef struct packed {
      logic       lock;
      logic       four_lane;
      logic [3:0] prot;
      logic       latch;
      logic       busy;
   } fsc_status_t;

   typedef struct packed {
      fsc_status_t status;
      logic [7:0]  cfg1;
      logic [7:0]  cfg2;
   } fsc_image_t;

   typedef struct packed {
      logic [7:0]  op;
      logic [23:0] payload;
      logic [5:0]  bits;
   } fsc_frame_t;

   typedef enum logic [1:0] {S_IDLE, S_CELL_OP, S_REG_WRITE} fsc_state_t;

endpackage

// >>> hdl/fsc_sync.sv
// Two-flop level synchroniser, one bit per lane.
// Assumes each lane is a slow level; no multi-bit coherence is given.
`timescale 1ns/100ps
`default_nettype none
module fsc_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Levels
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;

   // First stage feeds only the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule
`default_nettype wire

// >>> hdl/fsc_regs.sv
// Status and configuration registers of a serial NOR flash, with the
// serial front end for the two register reads and the commands that
// change the registers. Assumes the host drives sclk only while cs_n is
// low, and keeps cs_n high a few system clocks between frames.
//
// Summary of operation
// - Status read accepted anytime, even when busy
// - Status byte driven on serial output
// - Upper I/O lanes ignored during register reads
// - Config read accepted anytime, even when busy
// - Config bytes driven on serial output
// - Status bit 0 shows busy cycle
// - Latch-set command sets write latch
// - Program/erase ignored while latch clear
// - Latch clears when program/erase completes
// - Protected target: drop command, clear latch
// - Protect level bits only via status write
// - Protect bits guard program/erase; array wipe needs level 0
// - Four-lane bit disables guard and reset pins
// - Lock plus low guard pin rejects status writes
// - Low-end select is one-time settable
// - Config two bit 1 selects performance
// - Wait select picks 4/6 or 8/10
// - Latch clears on clear command, reset pin
`timescale 1ns/100ps
`default_nettype none
module fsc_regs #(
   parameter logic [15:0] PAGE_WRITE_CYCLES   = fsc_pkg::PAGE_WRITE_CYCLES,
   parameter logic [15:0] WIPE_CYCLES         = fsc_pkg::WIPE_CYCLES,
   parameter logic [15:0] STATUS_WRITE_CYCLES = fsc_pkg::STATUS_WRITE_CYCLES
) (
   // System clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Serial link
   input  wire logic       sclk,
   input  wire logic       cs_n,
   input  wire logic       si,
   input  wire logic [2:0] upper_io_lanes,
   output logic            so_r,
   output logic            so_oe_n_r,
   // Device pins
   input  wire logic       write_guard_pin_n,
   input  wire logic       reset_pin_n,
   // Block state
   output logic            busy_r,
   output logic            four_lane_r,
   output logic            high_perf_r,
   output logic [3:0]      wait_dual_r,
   output logic [3:0]      wait_quad_r
);
   // Saturating bit counter step
   function automatic logic [5:0] sat_inc(input logic [5:0] v);
      return (v == fsc_pkg::BITS_MAX) ? v : 6'(v + 6'h01);
   endfunction
   // Is the block inside the protected range
   function automatic logic is_protected(input logic [6:0] blk,
                                         input logic [3:0] lvl,
                                         input logic       low_end);
      logic [7:0] n;
      n = (lvl >= 4'h8) ? fsc_pkg::BLOCK_COUNT : 8'(8'h01 << 4'(lvl - 4'h1));
      if (lvl == 4'h0)
         return 1'b0;
      if (low_end)
         return {1'b0, blk} < n;
      return {1'b0, blk} >= 8'(fsc_pkg::BLOCK_COUNT - n);
   endfunction
   // ---------------- Link domain ----------------
   logic [5:0]          bit_cnt_r;
   logic [3:0]          out_cnt_r;
   fsc_pkg::fsc_frame_t frame_r;
   fsc_pkg::fsc_image_t img_r;
   logic                busy_link;
   logic [7:0]          out_byte;
   // Counters end with the frame: cs_n high clears them at once
   always_ff @(posedge sclk or posedge cs_n or posedge rst) begin
      if (rst) begin
         bit_cnt_r <= 6'h00;
         out_cnt_r <= 4'h0;
      end else if (cs_n) begin
         bit_cnt_r <= 6'h00;
         out_cnt_r <= 4'h0;
      end else begin
         bit_cnt_r <= sat_inc(bit_cnt_r);
         if (bit_cnt_r >= fsc_pkg::BITS_OPCODE)
            out_cnt_r <= 4'(out_cnt_r + 4'h1);
      end
   end
   // Frame capture outlives cs_n so the system side can decode it
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         frame_r <= '0;
      end else if (!cs_n) begin
         frame_r.bits <= sat_inc(bit_cnt_r);
         if (bit_cnt_r < fsc_pkg::BITS_OPCODE)
            frame_r.op <= {frame_r.op[6:0], si};
         if (bit_cnt_r == 6'h00)
            frame_r.payload <= 24'h000000;
         else if (bit_cnt_r >= fsc_pkg::BITS_OPCODE && bit_cnt_r < fsc_pkg::BITS_THREE)
            frame_r.payload <= {frame_r.payload[22:0], si};
      end
   end
   // Busy crosses as a level so a status read sees it live
   fsc_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_busy_sync (
      .clk (sclk),
      .rst (rst),
      .d   (busy_r),
      .q   (busy_link)
   );
   // Byte on the wire: status repeats, config alternates one and two
   always_comb begin
      if (frame_r.op == fsc_pkg::OP_READ_STATUS)
         out_byte = {img_r.status[7:1], busy_link};
      else
         out_byte = out_cnt_r[3] ? img_r.cfg2 : img_r.cfg1;
   end
   // Output changes on falling edges only; released when cs_n rises
   always_ff @(negedge sclk or posedge cs_n or posedge rst) begin
      if (rst) begin
         so_r      <= 1'b0;
         so_oe_n_r <= 1'b1;
      end else if (cs_n) begin
         so_r      <= 1'b0;
         so_oe_n_r <= 1'b1;
      end else if (bit_cnt_r >= fsc_pkg::BITS_OPCODE &&
                   (frame_r.op == fsc_pkg::OP_READ_STATUS ||
                    frame_r.op == fsc_pkg::OP_READ_CONFIG)) begin
         so_oe_n_r <= 1'b0;
         so_r      <= out_byte[3'(3'h7 - out_cnt_r[2:0])];
      end
   end
   // ---------------- System domain ----------------
   logic                 cs_s;
   logic                 guard_s;
   logic                 rpin_s;
   logic                 cs_prev_r;
   logic                 frame_end;
   fsc_pkg::fsc_state_t  state_r;
   logic [15:0]          cnt_r;
   logic                 latch_r;
   logic [3:0]           prot_r;
   logic                 lock_r;
   logic                 low_end_r;
   logic                 wait_sel_r;
   logic [23:0]          pend_r;
   logic [5:0]           pend_bits_r;
   logic                 hard_lock;
   logic                 rpin_act;
   logic                 op_cell;
   logic                 op_array;
   logic                 target_prot;
   logic                 cell_ok;
   logic                 cell_start;
   logic                 cell_drop;
   logic                 srw_start;
   logic                 done;
   logic                 latch_set;
   logic                 latch_clr;
   fsc_sync #(.WIDTH(3), .RST_VAL(3'h7)) u_pin_sync (
      .clk (clk),
      .rst (rst),
      .d   ({cs_n, write_guard_pin_n, reset_pin_n}),
      .q   ({cs_s, guard_s, rpin_s})
   );
   // Frame end is the synchronised rise of cs_n
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         cs_prev_r <= 1'b1;
      else
         cs_prev_r <= cs_s;
   end
   assign frame_end = cs_s & ~cs_prev_r;

   // Pin functions drop out in four-lane mode
   assign hard_lock = lock_r & ~guard_s & ~four_lane_r;
   assign rpin_act  = ~rpin_s & ~four_lane_r;

   // Command decode on a completed frame
   assign op_array = frame_r.op == fsc_pkg::OP_ARRAY_WIPE ||
                     frame_r.op == fsc_pkg::OP_ARRAY_WIPE_ALT;
   always_comb begin
      op_cell = 1'b0;
      case (frame_r.op)
         fsc_pkg::OP_PAGE_WRITE:      op_cell = frame_r.bits >= fsc_pkg::BITS_PAGE;
         fsc_pkg::OP_SECTOR_WIPE,
         fsc_pkg::OP_HALF_BLOCK_WIPE,
         fsc_pkg::OP_BLOCK_WIPE:      op_cell = frame_r.bits == fsc_pkg::BITS_THREE;
         fsc_pkg::OP_ARRAY_WIPE,
         fsc_pkg::OP_ARRAY_WIPE_ALT:  op_cell = frame_r.bits == fsc_pkg::BITS_OPCODE;
         default:                     op_cell = 1'b0;
      endcase
   end
   assign target_prot = op_array ? (prot_r != 4'h0) :
      is_protected(frame_r.payload[fsc_pkg::BLK_LSB +: 7], prot_r, low_end_r);
   assign cell_ok    = frame_end & op_cell & latch_r & (state_r == fsc_pkg::S_IDLE);
   assign cell_start = cell_ok & ~target_prot;
   assign cell_drop  = cell_ok & target_prot;
   assign srw_start  = frame_end & (frame_r.op == fsc_pkg::OP_STATUS_WRITE) & latch_r &
                       (state_r == fsc_pkg::S_IDLE) & ~hard_lock &
                       (frame_r.bits == fsc_pkg::BITS_ONE ||
                        frame_r.bits == fsc_pkg::BITS_TWO ||
                        frame_r.bits == fsc_pkg::BITS_THREE);
   assign done       = (state_r != fsc_pkg::S_IDLE) && (cnt_r == 16'h0001);

   // Self-timed busy cycles
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r     <= fsc_pkg::S_IDLE;
         cnt_r       <= 16'h0000;
         pend_r      <= 24'h000000;
         pend_bits_r <= 6'h00;
      end else begin
         case (state_r)
            fsc_pkg::S_IDLE: begin
               if (cell_start) begin
                  state_r <= fsc_pkg::S_CELL_OP;
                  cnt_r   <= (frame_r.op == fsc_pkg::OP_PAGE_WRITE) ?
                             PAGE_WRITE_CYCLES : WIPE_CYCLES;
               end else if (srw_start) begin
                  state_r     <= fsc_pkg::S_REG_WRITE;
                  cnt_r       <= STATUS_WRITE_CYCLES;
                  pend_r      <= frame_r.payload;
                  pend_bits_r <= frame_r.bits;
               end
            end
            fsc_pkg::S_CELL_OP,
            fsc_pkg::S_REG_WRITE: begin
               cnt_r <= 16'(cnt_r - 16'h0001);
               if (done)
                  state_r <= fsc_pkg::S_IDLE;
            end
            default: state_r <= fsc_pkg::S_IDLE;
         endcase
      end
   end

   // Busy mirrors the cycle state
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         busy_r <= 1'b0;
      else
         busy_r <= (cell_start | srw_start) | ((state_r != fsc_pkg::S_IDLE) & ~done);
   end

   // Write latch: a set in the same cycle as a clear wins
   assign latch_set = frame_end & (frame_r.op == fsc_pkg::OP_LATCH_SET) &
                      (frame_r.bits == fsc_pkg::BITS_OPCODE);
   assign latch_clr = (frame_end & (frame_r.op == fsc_pkg::OP_LATCH_CLEAR) &
                       (frame_r.bits == fsc_pkg::BITS_OPCODE)) | done | cell_drop | rpin_act;
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         latch_r <= 1'b0;
      else if (latch_set)
         latch_r <= 1'b1;
      else if (latch_clr)
         latch_r <= 1'b0;
   end

   // Register contents change only when a status write completes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {lock_r, four_lane_r, prot_r} <= fsc_pkg::STATUS_RST[7:2];
         low_end_r   <= fsc_pkg::CFG_RST[fsc_pkg::CF1_LOW_END];
         wait_sel_r  <= fsc_pkg::CFG_RST[fsc_pkg::CF1_WAIT];
         high_perf_r <= fsc_pkg::CFG_RST[fsc_pkg::CF2_PERF];
      end else if (done && state_r == fsc_pkg::S_REG_WRITE) begin
         if (pend_bits_r == fsc_pkg::BITS_ONE)
            {lock_r, four_lane_r, prot_r} <= pend_r[7:2];
         else if (pend_bits_r == fsc_pkg::BITS_TWO)
            {lock_r, four_lane_r, prot_r} <= pend_r[15:10];
         else
            {lock_r, four_lane_r, prot_r} <= pend_r[23:18];
         if (pend_bits_r == fsc_pkg::BITS_TWO) begin
            low_end_r  <= low_end_r | pend_r[fsc_pkg::CF1_LOW_END];
            wait_sel_r <= pend_r[fsc_pkg::CF1_WAIT];
         end else if (pend_bits_r == fsc_pkg::BITS_THREE) begin
            low_end_r   <= low_end_r | pend_r[8 + fsc_pkg::CF1_LOW_END];
            wait_sel_r  <= pend_r[8 + fsc_pkg::CF1_WAIT];
            high_perf_r <= pend_r[fsc_pkg::CF2_PERF];
         end
      end
   end

   // Wait cycles for the multi-lane reads
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_dual_r <= fsc_pkg::DUAL_WAIT_SHORT;
         wait_quad_r <= fsc_pkg::QUAD_WAIT_SHORT;
      end else begin
         wait_dual_r <= wait_sel_r ? fsc_pkg::DUAL_WAIT_LONG : fsc_pkg::DUAL_WAIT_SHORT;
         wait_quad_r <= wait_sel_r ? fsc_pkg::QUAD_WAIT_LONG : fsc_pkg::QUAD_WAIT_SHORT;
      end
   end

   // Image for the link, frozen while a frame is open
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         img_r <= '0;
      else if (cs_s)
         img_r <= {lock_r, four_lane_r, prot_r, latch_r, busy_r,
                   1'b0, wait_sel_r, 2'b00, low_end_r, 3'b000,
                   6'b000000, high_perf_r, 1'b0};
   end

   // ---------------- Checks ----------------
   a_latch_cause: assert property (@(posedge clk) disable iff (rst)
      $rose(latch_r) |-> $past(latch_set)) else $error("latch rose without set command");
   a_busy_start: assert property (@(posedge clk) disable iff (rst)
      (cell_start | srw_start) |=> busy_r && state_r != fsc_pkg::S_IDLE)
      else $error("busy not raised at cycle start");
   a_latch_end: assert property (@(posedge clk) disable iff (rst)
      (done && !latch_set) |=> !latch_r) else $error("latch kept after cycle end");
   a_no_latch: assert property (@(posedge clk) disable iff (rst)
      (frame_end && op_cell && !latch_r && state_r == fsc_pkg::S_IDLE) |=>
      state_r == fsc_pkg::S_IDLE) else $error("cell op started without latch");
   a_prot_drop: assert property (@(posedge clk) disable iff (rst)
      cell_drop |=> !latch_r && state_r == fsc_pkg::S_IDLE)
      else $error("protected target not dropped");
   a_array_guard: assert property (@(posedge clk) disable iff (rst)
      (frame_end && op_array && prot_r != 4'h0 && state_r == fsc_pkg::S_IDLE) |=> !busy_r)
      else $error("array wipe ran while protected");
   a_lock_reject: assert property (@(posedge clk) disable iff (rst)
      (frame_end && hard_lock && state_r == fsc_pkg::S_IDLE) |=>
      state_r != fsc_pkg::S_REG_WRITE) else $error("status write taken under lock");
   a_otp_sticky: assert property (@(posedge clk) disable iff (rst)
      $past(low_end_r) |-> low_end_r) else $error("low-end select was cleared");
   a_wait_map: assert property (@(posedge clk) disable iff (rst)
      wait_sel_r ##1 wait_sel_r |-> wait_dual_r == 4'h8 && wait_quad_r == 4'hA)
      else $error("wait cycles do not follow select");
   a_pin_clear: assert property (@(posedge clk) disable iff (rst)
      (rpin_act && !latch_set) |=> !latch_r) else $error("reset pin left latch set");
   a_read_drive: assert property (@(negedge sclk) disable iff (rst || cs_n)
      (bit_cnt_r > fsc_pkg::BITS_OPCODE && frame_r.op == fsc_pkg::OP_READ_STATUS) |->
      !so_oe_n_r) else $error("status read not driven");
endmodule
`default_nettype wire

// >>> sim/fsc_host.sv
// Serial host model: sends mode 0 frames, collects read bytes MSB first.
// Assumes the device shifts out on falling sclk edges while selected.
`timescale 1ns/100ps
`default_nettype none
module fsc_host (
   // Serial link
   output logic       sclk,
   output logic       cs_n,
   output logic       si,
   input  wire logic  so,
   input  wire logic  so_oe_n,
   // Collected bytes
   output logic [7:0] rx_byte,
   output logic       rx_stb
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
      rx_byte = 8'h00;
      rx_stb = 1'b0;
   end

   // One frame; sclk stands still outside it, si flips once released
   task automatic send(input logic [39:0] d, input int nb, input int nr);
      logic [7:0] b;
      #7 cs_n = 1'b0;
      for (int i = 0; i < nb; i++) begin
         si = d[39-i];
         #32 sclk = 1'b1;
         #32 sclk = 1'b0;
      end
      // A bit sampled while the output is off counts as unknown
      for (int k = 0; k < nr; k++) begin
         for (int i = 7; i >= 0; i--) begin
            #32 sclk = 1'b1;
            b[i] = so_oe_n ? 1'bx : so;
            #32 sclk = 1'b0;
         end
         rx_byte = b;
         rx_stb = 1'b1;
         #1 rx_stb = 1'b0;
      end
      #32 cs_n = 1'b1;
      si = ~si;
      #200;
   endtask
endmodule
`default_nettype wire

// >>> sim/fsc_regs_bench.sv
// Self-checking bench for the flash status and configuration registers.
// Assumes fsc_host as serial partner; self-timed cycles cut to 200 clk.
`timescale 1ns/100ps
`default_nettype none
module fsc_regs_bench;
   localparam logic [7:0] ST = fsc_pkg::OP_READ_STATUS;
   localparam logic [7:0] CF = fsc_pkg::OP_READ_CONFIG;
   localparam logic [7:0] WS = fsc_pkg::OP_STATUS_WRITE;
   logic        clk;
   logic        rst;
   logic        sclk;
   logic        cs_n;
   logic        si;
   logic        so;
   logic        so_oe_n;
   logic        guard_n;
   logic        rpin_n;
   logic [2:0]  lanes = 3'h0;
   logic        busy;
   logic        four_lane;
   logic        high_perf;
   logic [3:0]  wdual;
   logic [3:0]  wquad;
   logic [7:0]  rx_byte;
   logic        rx_stb;
   logic [15:0] expq[$];
   logic [15:0] note;
   logic [31:0] seed = 32'h0000004F;
   logic [7:0]  sw;
   logic [7:0]  ops [4];
   int          nbs [4] = '{40, 32, 32, 32};
   int          miscompares;
   int          total_checks;

   fsc_regs #(.PAGE_WRITE_CYCLES(16'h00C8), .WIPE_CYCLES(16'h00C8),
      .STATUS_WRITE_CYCLES(16'h00C8)) uut (
      .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si),
      .upper_io_lanes(lanes), .so_r(so), .so_oe_n_r(so_oe_n),
      .write_guard_pin_n(guard_n), .reset_pin_n(rpin_n), .busy_r(busy),
      .four_lane_r(four_lane), .high_perf_r(high_perf),
      .wait_dual_r(wdual), .wait_quad_r(wquad));

   fsc_host host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n),
      .rx_byte(rx_byte), .rx_stb(rx_stb));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   task automatic finish_test();
      if (miscompares == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Notes are {mask, value}; a read frame repeats e0, e1, e0, ...
   task automatic rd(input logic [7:0] op, input int n, input logic [15:0] e0,
                     input logic [15:0] e1);
      for (int k = 0; k < n; k++)
         expq.push_back(k[0] ? e1 : e0);
      host.send({op, 32'h0}, 8, n);
   endtask

   task automatic cmd(input logic [7:0] op);
      host.send({op, 32'h0}, 8, 0);
   endtask

   // Bounded poll of the busy port
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      chk({7'h00, busy}, 8'h00);
   endtask

   // Oldest note against each collected byte
   always @(posedge rx_stb) begin
      note = expq.pop_front();
      chk(rx_byte & note[15:8], note[7:0]);
   end

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Upper lanes get noise all the time; the reads must not care
   always @(posedge clk) begin
      seed <= xs(seed);
      lanes <= seed[2:0];
   end

   initial begin
      #1000000;
      miscompares++;
      finish_test();
   end

   initial begin
      miscompares = 0;
      total_checks = 0;
      rst = 1'b1;
      guard_n = 1'b1;
      rpin_n = 1'b1;
      ops = '{fsc_pkg::OP_PAGE_WRITE, fsc_pkg::OP_SECTOR_WIPE,
              fsc_pkg::OP_HALF_BLOCK_WIPE, fsc_pkg::OP_BLOCK_WIPE};
      // Protect level 1..7 keeps block zero open at the top setting
      sw = {2'b00, 4'((xs(32'h0000004F) % 7) + 1), 2'b00};
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      // Reset values
      rd(ST, 2, 16'hFF00, 16'hFF00);
      rd(CF, 3, 16'hFF00, 16'hFF00);
      chk({wdual, wquad}, 8'h46);
      chk({6'h00, four_lane, high_perf}, 8'h00);
      cmd(fsc_pkg::OP_LATCH_SET);
      rd(ST, 1, 16'hFF02, 16'hFF02);
      cmd(fsc_pkg::OP_LATCH_CLEAR);
      rd(ST, 1, 16'hFF00, 16'hFF00);
      // Writes without the latch go nowhere
      host.send({fsc_pkg::OP_PAGE_WRITE, 32'h0}, 40, 0);
      host.send({WS, sw, 24'h0}, 16, 0);
      chk({7'h00, busy}, 8'h00);
      rd(ST, 1, 16'hFF00, 16'hFF00);
      // Full register write, busy seen by a read in mid-cycle
      cmd(fsc_pkg::OP_LATCH_SET);
      host.send({WS, sw, 8'h40, 8'h02, 8'h00}, 32, 0);
      rd(ST, 1, 16'h0101, 16'h0101);
      wait_idle();
      rd(ST, 1, {8'hFF, sw}, {8'hFF, sw});
      rd(CF, 3, 16'hFF40, 16'hFF02);
      chk({wdual, wquad}, 8'h8A);
      chk({7'h00, high_perf}, 8'h01);
      // Top block and whole array are guarded
      cmd(fsc_pkg::OP_LATCH_SET);
      host.send({fsc_pkg::OP_BLOCK_WIPE, 24'h7F0000, 8'h00}, 32, 0);
      chk({7'h00, busy}, 8'h00);
      rd(ST, 1, {8'hFF, sw}, {8'hFF, sw});
      cmd(fsc_pkg::OP_LATCH_SET);
      cmd(fsc_pkg::OP_ARRAY_WIPE);
      rd(ST, 1, {8'hFF, sw}, {8'hFF, sw});
      // Page write and sector, half-block and block wipe at block zero run, then drop the latch
      for (int i = 0; i < 4; i++) begin
         cmd(fsc_pkg::OP_LATCH_SET);
         host.send({ops[i], 32'h0}, nbs[i], 0);
         rd(ST, 1, 16'h0303, 16'h0303);
         wait_idle();
         rd(ST, 1, {8'hFF, sw}, {8'hFF, sw});
      end
      // Low-end bit only sets; wait select and performance go back
      cmd(fsc_pkg::OP_LATCH_SET);
      host.send({WS, sw | 8'h80, 8'h08, 16'h0000}, 32, 0);
      wait_idle();
      cmd(fsc_pkg::OP_LATCH_SET);
      host.send({WS, sw | 8'h80, 8'h00, 16'h0000}, 24, 0);
      wait_idle();
      rd(CF, 3, 16'hFF08, 16'hFF00);
      chk({wdual, wquad}, 8'h46);
      chk({7'h00, high_perf}, 8'h00);
      // Lock with guard low refuses the write, latch kept
      @(posedge clk) guard_n <= 1'b0;
      cmd(fsc_pkg::OP_LATCH_SET);
      host.send({WS, 8'h00, 24'h0}, 16, 0);
      chk({7'h00, busy}, 8'h00);
      rd(ST, 1, {8'hFF, sw | 8'h82}, 16'h0000);
      @(posedge clk) guard_n <= 1'b1;
      // Reset pin clears only the latch
      @(posedge clk) rpin_n <= 1'b0;
      repeat (10) @(posedge clk);
      rpin_n <= 1'b1;
      repeat (5) @(posedge clk);
      rd(ST, 1, {8'hFF, sw | 8'h80}, 16'h0000);
      // Four-lane mode drops the guard and reset pin functions
      cmd(fsc_pkg::OP_LATCH_SET);
      host.send({WS, sw | 8'hC0, 24'h0}, 16, 0);
      wait_idle();
      chk({7'h00, four_lane}, 8'h01);
      @(posedge clk) guard_n <= 1'b0;
      rpin_n <= 1'b0;
      cmd(fsc_pkg::OP_LATCH_SET);
      rd(ST, 1, {8'hFF, sw | 8'hC2}, 16'h0000);
      host.send({WS, sw, 24'h0}, 16, 0);
      rd(ST, 1, 16'h0101, 16'h0101);
      wait_idle();
      rd(ST, 1, {8'hFF, sw}, 16'h0000);
      @(posedge clk) guard_n <= 1'b1;
      rpin_n <= 1'b1;
      repeat (20) @(posedge clk);
      finish_test();
   end
endmodule
`default_nettype wire
